// ==== src/spu_top.v ====
/*
 * system protection unit: module base register and address decode, bus
 * time-out monitor, spurious interrupt monitor and software watchdog.
 * assumes a core on clk driving the register and control ports, and
 * bus terminations arriving from pins outside the clock domain.
 */
// Design decisions made here: the plain strobed port and the address map.
`include "spu_defines.vh"

module spu_top
#(
    parameter WDT_BASE_SHIFT = 9,
    parameter WDT_PRESC_SHIFT = 9
)
(
    // clock and reset
    input wire clk,
    input wire rstn,
    // register bus
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // control space and debug access
    input wire ctrl_wr,
    input wire [11:0] ctrl_addr,
    input wire [31:0] ctrl_wdata,
    input wire supervisor,
    input wire debug_mode,
    input wire dbg_rd,
    output reg [31:0] dbg_rdata,
    // core access decode
    input wire [31:0] access_addr,
    input wire [2:0] access_space,
    output wire access_internal,
    // bus cycle tracking
    input wire transfer_start,
    input wire line_transfer,
    input wire transfer_acknowledge_n,
    input wire auto_transfer_acknowledge_n,
    input wire transfer_error_acknowledge_n,
    output reg transfer_error_internal,
    output reg transfer_abort,
    // interrupt acknowledge
    input wire iack_cycle,
    input wire [2:0] iack_level,
    input wire [7:1] pending_levels,
    output reg vec_valid,
    output reg [7:0] vec_data,
    output reg access_error,
    // watchdog outputs
    input wire reset_out_select,
    output reg wdt_irq,
    output wire [2:0] wdt_irq_level,
    output reg wdt_internal_reset,
    output reg reset_output
);

localparam WDT_W = 25;
localparam WS_RUN = 1'b0;
localparam WS_RESET = 1'b1;

reg mbr_valid;
reg [31:1] mbr_field;
reg [7:0] protection_control_register;
reg prot_written;
reg [7:0] watchdog_vector_register;
reg hard_reset_flag;
reg software_reset_flag;
reg svc_armed;
reg [WDT_W-1:0] wdt_count;
reg wdt_state;
reg [5:0] rst_count;
reg [2:0] pin_meta;
reg [2:0] pin_sync;
reg [2:0] pin_prev;
reg in_iack;
reg [2:0] iack_lvl;
reg [31:0] next_rdata;

wire [31:0] module_base_register = {mbr_field, mbr_valid};
wire bm_busy;
wire bm_timeout;
wire ta_seen = !pin_sync[0];
wire ata_seen = !pin_sync[1];
wire tea_seen = !pin_sync[2] && pin_prev[2];
wire cycle_internal = access_internal;
wire wdt_en = protection_control_register[`SPU_PC_WDT_EN];
wire wdt_rst_mode = protection_control_register[`SPU_PC_WDT_RSTSEL];
wire svc_write = reg_wr && reg_addr == `SPU_OFS_WDT_SVC;
wire svc_done = svc_write && reg_wdata[7:0] == `SPU_SVC_SECOND && svc_armed;
wire wdt_expire = wdt_state == WS_RUN && wdt_en && wdt_count == {WDT_W{1'b0}};
wire prot_write = reg_wr && reg_addr == `SPU_OFS_PROT_CTRL && !prot_written;
wire [7:0] pc_load = prot_write ? reg_wdata[7:0] : protection_control_register;

// address space mask lookup
function space_masked;
    input [31:0] mbr;
    input [2:0] space;
    begin
        case (space)
            3'h0: space_masked = mbr[`SPU_MBR_MASK_LO];
            3'h1: space_masked = mbr[`SPU_MBR_MASK_LO + 1];
            3'h2: space_masked = mbr[`SPU_MBR_MASK_LO + 2];
            3'h3: space_masked = mbr[`SPU_MBR_MASK_LO + 3];
            3'h4: space_masked = mbr[`SPU_MBR_MASK_HI];
            default: space_masked = 1'b0;
        endcase
    end
endfunction

// watchdog full period from prescale and timing field
function [WDT_W-1:0] wdt_period;
    input [7:0] pc;
    reg [4:0] sh;
    begin
        sh = WDT_BASE_SHIFT[4:0] + {2'b00, pc[`SPU_PC_WDT_TIME_HI:`SPU_PC_WDT_TIME_LO], 1'b0};
        if (pc[`SPU_PC_WDT_PRESC])
            sh = sh + WDT_PRESC_SHIFT[4:0];
        wdt_period = ({{(WDT_W-1){1'b0}}, 1'b1} << sh) - {{(WDT_W-1){1'b0}}, 1'b1};
    end
endfunction

// base match and space masking
assign access_internal = module_base_register[`SPU_MBR_VALID]
    && module_base_register[31:`SPU_MBR_BASE_LO] == access_addr[31:`SPU_MBR_BASE_LO]
    && !space_masked(module_base_register, access_space);

assign wdt_irq_level = `SPU_WDT_LEVEL;

// pin terminations pass two flip-flops
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        pin_meta <= 3'h7;
        pin_sync <= 3'h7;
        pin_prev <= 3'h7;
    end
    else
    begin
        pin_meta <= {transfer_error_acknowledge_n, auto_transfer_acknowledge_n, transfer_acknowledge_n};
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end
end

spu_bus_monitor spu_bus_monitor_i
(
    .clk(clk),
    .rstn(rstn),
    .start(transfer_start),
    .line(line_transfer),
    .term(ta_seen || ata_seen),
    .monitor_on(protection_control_register[`SPU_PC_BM_EN] || cycle_internal),
    .time_sel(protection_control_register[`SPU_PC_BM_TIME_HI:`SPU_PC_BM_TIME_LO]),
    .busy(bm_busy),
    .timeout(bm_timeout)
);

// time-out raises transfer error and aborts the cycle
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        transfer_error_internal <= 1'b0;
        transfer_abort <= 1'b0;
    end
    else
    begin
        transfer_error_internal <= bm_timeout;
        transfer_abort <= bm_timeout || (tea_seen && bm_busy);
    end
end

// module base register, control space and debug read
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        mbr_valid <= 1'b0;
        dbg_rdata <= 32'h00000000;
    end
    else
    begin
        if (ctrl_wr && supervisor && ctrl_addr == `SPU_CTRL_MBR)
            mbr_valid <= ctrl_wdata[`SPU_MBR_VALID];
        dbg_rdata <= (dbg_rd && debug_mode) ? module_base_register : 32'h00000000;
    end
end

// upper bits have no reset value
always @(posedge clk)
begin
    if (ctrl_wr && supervisor && ctrl_addr == `SPU_CTRL_MBR)
        mbr_field <= ctrl_wdata[31:1];
end

// protection control write-once and vector register
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        protection_control_register <= `SPU_PC_RESET;
        prot_written <= 1'b0;
        watchdog_vector_register <= `SPU_WDT_VEC_RESET;
    end
    else
    begin
        if (reg_wr && reg_addr == `SPU_OFS_PROT_CTRL && !prot_written)
        begin
            protection_control_register <= reg_wdata[7:0];
            prot_written <= 1'b1;
        end
        if (reg_wr && reg_addr == `SPU_OFS_WDT_VEC)
            watchdog_vector_register <= reg_wdata[7:0];
    end
end

// interrupt acknowledge and spurious monitor
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        in_iack <= 1'b0;
        iack_lvl <= 3'h0;
        vec_valid <= 1'b0;
        vec_data <= 8'h00;
        access_error <= 1'b0;
    end
    else
    begin
        vec_valid <= 1'b0;
        access_error <= 1'b0;
        if (iack_cycle)
        begin
            iack_lvl <= iack_level;
            if (iack_level == `SPU_WDT_LEVEL && wdt_irq)
            begin
                vec_valid <= 1'b1;
                vec_data <= watchdog_vector_register;
            end
            else if (iack_level == 3'h0 || !pending_levels[iack_level])
            begin
                vec_valid <= 1'b1;
                vec_data <= `SPU_SPURIOUS_VEC;
            end
            else
                in_iack <= 1'b1;
        end
        else if (in_iack)
        begin
            if (tea_seen)
            begin
                in_iack <= 1'b0;
                vec_valid <= 1'b1;
                vec_data <= `SPU_SPURIOUS_VEC;
            end
            else if (ta_seen || ata_seen)
                in_iack <= 1'b0;
            else if (bm_timeout)
            begin
                in_iack <= 1'b0;
                access_error <= 1'b1;
            end
        end
    end
end

// watchdog service sequence
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        svc_armed <= 1'b0;
    else if (svc_write && reg_wdata[7:0] == `SPU_SVC_FIRST)
        svc_armed <= 1'b1;
    else if (svc_done)
        svc_armed <= 1'b0;
end

// watchdog counter, expiry and reset pulse
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        wdt_count <= {WDT_W{1'b1}};
        wdt_state <= WS_RUN;
        rst_count <= 6'h00;
        wdt_irq <= 1'b0;
        wdt_internal_reset <= 1'b0;
        reset_output <= 1'b0;
        hard_reset_flag <= 1'b1;
        software_reset_flag <= 1'b0;
    end
    else
    begin
        case (wdt_state)
            WS_RUN:
            begin
                if (!wdt_en || (svc_done && !wdt_expire))
                begin
                    wdt_count <= wdt_period(pc_load);
                    if (svc_done)
                        wdt_irq <= 1'b0;
                end
                else if (wdt_expire)
                begin
                    wdt_count <= wdt_period(protection_control_register);
                    if (wdt_rst_mode)
                    begin
                        wdt_state <= WS_RESET;
                        rst_count <= `SPU_WDT_RST_CYC - 6'h01;
                        wdt_internal_reset <= 1'b1;
                        reset_output <= reset_out_select;
                        hard_reset_flag <= 1'b0;
                        software_reset_flag <= 1'b1;
                    end
                    else
                        wdt_irq <= 1'b1;
                end
                else
                    wdt_count <= wdt_count - {{(WDT_W-1){1'b0}}, 1'b1};
            end
            WS_RESET:
            begin
                if (rst_count == 6'h00)
                begin
                    wdt_state <= WS_RUN;
                    wdt_internal_reset <= 1'b0;
                    reset_output <= 1'b0;
                end
                else
                    rst_count <= rst_count - 6'h01;
            end
            default:
                wdt_state <= WS_RUN;
        endcase
    end
end

// register read mux
always @*
begin
    next_rdata = 32'h00000000;
    case (reg_addr)
        `SPU_OFS_PROT_CTRL: next_rdata[7:0] = protection_control_register;
        `SPU_OFS_WDT_VEC: next_rdata[7:0] = watchdog_vector_register;
        `SPU_OFS_RST_STAT:
        begin
            next_rdata[`SPU_RS_HARD] = hard_reset_flag;
            next_rdata[`SPU_RS_SOFT] = software_reset_flag;
        end
        `SPU_OFS_STATUS: next_rdata[3:0] = {bm_busy, svc_armed, prot_written, wdt_irq};
        default: next_rdata = 32'h00000000;
    endcase
end

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        reg_rdata <= 32'h00000000;
    else
        reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
end

endmodule

// ==== src/spu_defines.vh ====
/*
 * constants of the system protection unit: register offsets, field
 * positions, reset values and timing counts.
 * assumes inclusion by bare name from the design files under src/.
 */
`ifndef SPU_DEFINES_VH
`define SPU_DEFINES_VH

// register bus offsets (byte addresses)
`define SPU_OFS_PROT_CTRL 8'h00
`define SPU_OFS_WDT_VEC 8'h04
`define SPU_OFS_WDT_SVC 8'h08
`define SPU_OFS_RST_STAT 8'h0C
`define SPU_OFS_STATUS 8'h10

// control space location of the module base register
`define SPU_CTRL_MBR 12'hC0F

// module base register fields
`define SPU_MBR_VALID 0
`define SPU_MBR_MASK_LO 1
`define SPU_MBR_MASK_HI 5
`define SPU_MBR_BASE_LO 10

// protection control register fields
`define SPU_PC_WDT_EN 7
`define SPU_PC_WDT_RSTSEL 6
`define SPU_PC_WDT_PRESC 5
`define SPU_PC_WDT_TIME_HI 4
`define SPU_PC_WDT_TIME_LO 3
`define SPU_PC_BM_EN 2
`define SPU_PC_BM_TIME_HI 1
`define SPU_PC_BM_TIME_LO 0
`define SPU_PC_RESET 8'h00

// reset status fields
`define SPU_RS_HARD 7
`define SPU_RS_SOFT 5

// service sequence values
`define SPU_SVC_FIRST 8'h55
`define SPU_SVC_SECOND 8'hAA

// vectors and levels
`define SPU_SPURIOUS_VEC 8'h18
`define SPU_WDT_LEVEL 3'h7
`define SPU_WDT_VEC_RESET 8'h0F

// timing counts in clock cycles and the line transfer beat count
`define SPU_BM_BASE_CYC 11'h080
`define SPU_WDT_RST_CYC 6'h20
`define SPU_LINE_BEATS 3'h4

`endif

// ==== src/spu_bus_monitor.v ====
/*
 * bus time-out monitor: counts from transfer start until one clock after
 * the final termination and flags a time-out.
 * assumes start and terminations already in the clk domain.
 */
`include "spu_defines.vh"

module spu_bus_monitor
(
    // clock and reset
    input wire clk,
    input wire rstn,
    // transfer events
    input wire start,
    input wire line,
    input wire term,
    input wire monitor_on,
    input wire [1:0] time_sel,
    // results
    output reg busy,
    output reg timeout
);

reg [10:0] count;
reg [2:0] beats;
reg stopping;

wire [10:0] limit = `SPU_BM_BASE_CYC << time_sel;

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        count <= 11'h000;
        beats <= 3'h0;
        busy <= 1'b0;
        stopping <= 1'b0;
        timeout <= 1'b0;
    end
    else
    begin
        timeout <= 1'b0;
        if (start)
        begin
            // counting begins on the start cycle
            count <= 11'h001;
            beats <= line ? `SPU_LINE_BEATS : 3'h1;
            busy <= monitor_on;
            stopping <= 1'b0;
        end
        else if (busy)
        begin
            if (stopping)
            begin
                busy <= 1'b0;
                stopping <= 1'b0;
            end
            else if (term && beats == 3'h1)
                stopping <= 1'b1;
            else if (term)
                beats <= beats - 3'h1;
            if (!stopping && count == limit - 11'h001)
            begin
                timeout <= 1'b1;
                busy <= 1'b0;
            end
            else
                count <= count + 11'h001;
        end
    end
end

endmodule

// ==== sim/spu_bus_partner.sv ====
/*
 * far side bus slave: answers each transfer start.
 * drives the pins high when idle; mode 0 silent, 1 prompt, 2 error, 3 slow.
 */
module spu_bus_partner
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request and mode
    input wire logic start,
    input wire logic line,
    input wire logic [1:0] mode,
    // termination pins
    output logic ta_n,
    output logic ata_n,
    output logic tea_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int dly;
    int beats;
    always @(posedge clk or negedge rstn)
    begin
        ta_n <= 1'h1;
        ata_n <= 1'h1;
        tea_n <= 1'h1;
        if (!rstn)
            beats <= 0;
        else if (start)
        begin
            dly <= (mode == 2'h3) ? 6 : 0;
            beats <= line ? 4 : 1;
        end
        else if (beats > 0 && dly > 0)
            dly <= dly - 1;
        else if (beats > 0 && mode == 2'h2)
        begin
            tea_n <= 1'h0;
            beats <= 0;
        end
        else if (beats > 0 && mode != 2'h0)
        begin
            ata_n <= !beats[0];
            ta_n <= beats[0];
            beats <= beats - 1;
        end
    end
endmodule

// ==== sim/spu_top_checker.sv ====
/*
 * checker of the protection unit, bound to the top module.
 * assumes the top module's port names.
 */
module spu_top_checker
(
    // clock and reset
    input wire clk,
    input wire rstn,
    // control and debug
    input wire ctrl_wr,
    input wire [11:0] ctrl_addr,
    input wire [31:0] ctrl_wdata,
    input wire supervisor,
    input wire debug_mode,
    input wire dbg_rd,
    input wire [31:0] dbg_rdata,
    input wire access_internal,
    // bus and interrupts
    input wire transfer_start,
    input wire transfer_error_internal,
    input wire transfer_abort,
    input wire iack_cycle,
    input wire [2:0] iack_level,
    input wire [7:1] pending_levels,
    input wire vec_valid,
    input wire [7:0] vec_data,
    input wire access_error,
    input wire wdt_irq,
    input wire [2:0] wdt_irq_level,
    input wire wdt_internal_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] hi_cnt;
    always @(posedge clk or negedge rstn)
        if (!rstn)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= wdt_internal_reset ? hi_cnt + 8'h01 : 8'h00;
    sequence s_blind;
        dbg_rd && !debug_mode;
    endsequence
    sequence s_spur;
        iack_cycle && iack_level != 3'h0 && !pending_levels[iack_level] && !(iack_level == 3'h7 && wdt_irq);
    endsequence
    AST_IRQ_LEVEL: assert property (wdt_irq_level == 3'h7) else $error("irq level wrong");
    AST_DBG_HIDDEN: assert property (s_blind |=> dbg_rdata == 32'h0) else $error("base read outside debug");
    AST_INVALID_BASE: assert property (ctrl_wr && supervisor && ctrl_addr == 12'hC0F && !ctrl_wdata[0]
        |=> !access_internal) else $error("decode without valid bit");
    AST_ERR_ABORT: assert property (transfer_error_internal |-> transfer_abort) else $error("no abort");
    AST_BM_MIN: assert property (transfer_start |=> !transfer_error_internal [*8]) else $error("early error");
    AST_SPURIOUS: assert property (s_spur |=> vec_valid && vec_data == 8'h18) else $error("no spurious");
    AST_WDT_VEC: assert property (iack_cycle && iack_level == 3'h7 && wdt_irq
        |=> vec_valid && !access_error) else $error("no watchdog vector");
    AST_RST_LEN: assert property ($fell(wdt_internal_reset) |-> hi_cnt == 8'h20) else $error("reset length");
    AST_ACC_XOR: assert property (vec_valid |-> !access_error) else $error("vector with error");
endmodule
bind spu_top spu_top_checker spu_top_checker_i (.clk(clk), .rstn(rstn), .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr),
    .ctrl_wdata(ctrl_wdata), .supervisor(supervisor), .debug_mode(debug_mode), .dbg_rd(dbg_rd),
    .dbg_rdata(dbg_rdata), .access_internal(access_internal), .transfer_start(transfer_start),
    .transfer_error_internal(transfer_error_internal), .transfer_abort(transfer_abort), .iack_cycle(iack_cycle),
    .iack_level(iack_level), .pending_levels(pending_levels), .vec_valid(vec_valid), .vec_data(vec_data),
    .access_error(access_error), .wdt_irq(wdt_irq), .wdt_irq_level(wdt_irq_level),
    .wdt_internal_reset(wdt_internal_reset));

// ==== sim/tb_spu_top.sv ====
/*
 * testbench of the protection unit: register, decode, monitor, iack, watchdog.
 * assumes shortened watchdog shifts 6 and 1.
 */
module tb_spu_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, ctrl_wr = 0, supervisor = 0, debug_mode = 0, dbg_rd = 0;
    logic transfer_start = 0, line_transfer = 0, iack_cycle = 0, reset_out_select = 0;
    logic [7:0] reg_addr = 0;
    logic [11:0] ctrl_addr = 0;
    logic [31:0] reg_wdata = 0, ctrl_wdata = 0, access_addr = 0;
    logic [2:0] access_space = 0, iack_level = 0;
    logic [7:1] pending_levels = 0;
    logic [1:0] pmode = 0;
    wire transfer_acknowledge_n, auto_transfer_acknowledge_n, transfer_error_acknowledge_n, access_internal;
    wire transfer_error_internal, transfer_abort, vec_valid, access_error, wdt_irq, wdt_internal_reset, reset_output;
    wire [31:0] reg_rdata, dbg_rdata;
    wire [7:0] vec_data;
    wire [2:0] wdt_irq_level;
    int err_total = 0, tests_run = 0, n;
    always #12.5 clk = ~clk;
    spu_top #(.WDT_BASE_SHIFT(6), .WDT_PRESC_SHIFT(1)) spu_top_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_wr(ctrl_wr),
        .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .supervisor(supervisor), .debug_mode(debug_mode),
        .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .access_addr(access_addr), .access_space(access_space),
        .access_internal(access_internal), .transfer_start(transfer_start), .line_transfer(line_transfer),
        .transfer_acknowledge_n(transfer_acknowledge_n), .auto_transfer_acknowledge_n(auto_transfer_acknowledge_n),
        .transfer_error_acknowledge_n(transfer_error_acknowledge_n), .transfer_error_internal(transfer_error_internal),
        .transfer_abort(transfer_abort), .iack_cycle(iack_cycle), .iack_level(iack_level),
        .pending_levels(pending_levels), .vec_valid(vec_valid), .vec_data(vec_data), .access_error(access_error),
        .reset_out_select(reset_out_select), .wdt_irq(wdt_irq), .wdt_irq_level(wdt_irq_level),
        .wdt_internal_reset(wdt_internal_reset), .reset_output(reset_output));
    spu_bus_partner spu_bus_partner_i (.clk(clk), .rstn(rstn), .start(transfer_start), .line(line_transfer),
        .mode(pmode), .ta_n(transfer_acknowledge_n), .ata_n(auto_transfer_acknowledge_n),
        .tea_n(transfer_error_acknowledge_n));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: sig = transfer_error_internal;
            1: sig = wdt_irq;
            2: sig = wdt_internal_reset;
            default: sig = vec_valid | access_error;
        endcase
    endfunction
    task wait_for(input int w, input logic lvl, input int lim);
        n = 0;
        while (sig(w) !== lvl && n < lim)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= lim)
        begin
            err_total++;
            $display("[FAIL] wait %0d ran out", w);
            final_report;
        end
    endtask
    task quiet(input int cyc);
        logic seen;
        seen = 0;
        repeat (cyc) @(posedge clk) seen |= transfer_error_internal;
        chk("no_bus_error", seen, 0);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    task cwr(input logic sup, input logic [31:0] d);
        @(posedge clk);
        ctrl_wr <= 1'h1;
        supervisor <= sup;
        ctrl_addr <= 12'hC0F;
        ctrl_wdata <= d;
        @(posedge clk);
        ctrl_wr <= 1'h0;
    endtask
    task dbg(input logic m, input logic [31:0] e);
        @(posedge clk);
        debug_mode <= m;
        dbg_rd <= 1'h1;
        @(posedge clk);
        dbg_rd <= 1'h0;
        #1 chk("dbg_rdata", dbg_rdata, e);
    endtask
    task acc(input logic [31:0] a, input logic [2:0] sp, input logic e);
        @(posedge clk);
        access_addr <= a;
        access_space <= sp;
        #1 chk("access_internal", access_internal, e);
    endtask
    task xfer(input logic ln, input logic [1:0] md);
        @(posedge clk);
        transfer_start <= 1'h1;
        line_transfer <= ln;
        pmode <= md;
        @(posedge clk);
        transfer_start <= 1'h0;
    endtask
    task do_iack(input logic [2:0] lv, input logic [7:1] pd, input logic [1:0] md, input logic ev, input logic [7:0] ed);
        @(posedge clk);
        iack_level <= lv;
        pending_levels <= pd;
        pmode <= md;
        iack_cycle <= 1'h1;
        line_transfer <= 1'h0;
        transfer_start <= 1'h1;
        @(posedge clk);
        iack_cycle <= 1'h0;
        transfer_start <= 1'h0;
        #1 wait_for(3, 1, 300);
        chk("vec_valid", vec_valid, ev);
        chk("access_error", access_error, !ev);
        if (ev)
            chk("vec_data", vec_data, ed);
        repeat (8) @(posedge clk);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        rd(8'h0C, 32'h80);
        rd(8'h04, 32'h0F);
        rd(8'h14, 32'h0);
        chk("wdt_irq_level", wdt_irq_level, 32'h7);
        acc(32'h100007FC, 3'h0, 0);
        cwr(0, 32'h10000401);
        acc(32'h100007FC, 3'h0, 0);
        cwr(1, 32'h10000401);
        acc(32'h100007FC, 3'h0, 1);
        acc(32'h10000800, 3'h0, 0);
        dbg(0, 32'h0);
        dbg(1, 32'h10000401);
        cwr(1, 32'h10000400);
        acc(32'h10000400, 3'h5, 0);
        cwr(1, 32'h10000409);
        acc(32'h10000400, 3'h2, 0);
        acc(32'h10000400, 3'h5, 1);
        xfer(0, 0);
        wait_for(0, 1, 200);
        chk("bm_internal", n >= 124 && n <= 130, 1);
        chk("transfer_abort", transfer_abort, 1);
        acc(32'h20000000, 3'h0, 0);
        xfer(0, 0);
        quiet(300);
        wr(8'h00, 32'h85);
        wr(8'h00, 32'h00);
        rd(8'h00, 32'h85);
        rd(8'h10, 32'h2);
        xfer(0, 0);
        wait_for(0, 1, 400);
        chk("bm_256", n >= 252 && n <= 258, 1);
        xfer(1, 3);
        quiet(400);
        chk("wdt_irq", wdt_irq, 1);
        wr(8'h08, 32'hAA);
        #1 chk("wdt_irq", wdt_irq, 1);
        wr(8'h08, 32'h55);
        wr(8'h08, 32'h12);
        rd(8'h08, 32'h0);
        wr(8'h08, 32'hAA);
        #1 chk("wdt_irq", wdt_irq, 0);
        wait_for(1, 1, 100);
        chk("wdt_period", n >= 60 && n <= 68, 1);
        wr(8'h04, 32'h5A);
        do_iack(3'h7, 7'h00, 2'h1, 1, 8'h5A);
        do_iack(3'h3, 7'h00, 2'h1, 1, 8'h18);
        do_iack(3'h3, 7'h04, 2'h2, 1, 8'h18);
        do_iack(3'h3, 7'h04, 2'h0, 0, 8'h00);
        @(posedge clk);
        rstn <= 1'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        reset_out_select <= 1'h1;
        wr(8'h00, 32'hE8);
        wait_for(2, 1, 600);
        chk("wdt_reset_period", n >= 505 && n <= 520, 1);
        chk("reset_output", reset_output, 1);
        wait_for(2, 0, 100);
        chk("reset_length", n, 32);
        rd(8'h0C, 32'h20);
        final_report;
    end
endmodule
